// >>> ibtq_free_pick.sv
// lowest free slot finder
module ibtq_free_pick #(
  parameter int N   = 4,
  parameter int W   = 2
) (
  input  wire logic [N-1:0] busy_i,
  output logic      [W-1:0] idx_o
);

  always_comb begin
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (!busy_i[i]) begin
        idx_o = W'(i);
      end
    end
  end

endmodule : ibtq_free_pick

// >>> ibtq_link_sink.sv
// host link stream sink model with selectable stall and slow ready patterns
module ibtq_link_sink (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 valid_i,
  input  wire ibtq_pkg::ibtq_beat_s beat_i,
  input  wire logic                 hold_i,
  input  wire logic                 slow_i,
  output logic                      ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import ibtq_pkg::*;

  ibtq_beat_s  got[$];
  int unsigned stamp[$];
  int unsigned cyc;
  logic        tog_q;

  ////////////////////////////////////////////////////////////////////////////////
  // ready is registered, like a real link that reacts a cycle late
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_o <= 1'b0;
      tog_q   <= 1'b0;
      cyc     <= 0;
    end else begin
      cyc     <= cyc + 1;
      tog_q   <= ~tog_q;
      ready_o <= !hold_i && (!slow_i || tog_q);
      if (valid_i && ready_o) begin
        got.push_back(beat_i);
        stamp.push_back(cyc);
      end
    end
  end
endmodule : ibtq_link_sink

// >>> ibtq_pkg.sv
// constants, field layouts and beat type for the image block transfer queue
package ibtq_pkg;

  localparam int NSLOT  = 4;
  localparam int SLOT_W = 2;
  localparam int MAXW   = 16;
  localparam int PTR_W  = 5;
  localparam int WORD_W = 32;
  localparam int CNT_W  = 16;
  localparam int OCC_W  = 3;
  localparam int ADDR_W = 8;

  localparam logic [PTR_W-1:0] PKT_WORDS = 5'h04;
  localparam logic [PTR_W-1:0] LAST_PTR  = 5'h0F;
  localparam logic [OCC_W-1:0] OCC_FULL  = 3'h4;

  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TARGET   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CAPACITY = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_OCCUPY   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LOST     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ORDER    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1C;

  localparam int CTRL_METHOD_LSB = 0;
  localparam int CTRL_MODE_BIT   = 2;
  localparam int CTRL_OPEN_BIT   = 3;
  localparam int CMD_GO_BIT      = 0;
  localparam int CMD_HALT_BIT    = 1;

  localparam logic [1:0] METHOD_BASIC = 2'h0;
  localparam logic [1:0] METHOD_AUTO  = 2'h1;
  localparam logic [1:0] METHOD_USER  = 2'h2;
  localparam logic       MODE_CONT    = 1'h0;
  localparam logic       MODE_MULTI   = 1'h1;

  localparam logic [3:0]       CTRL_RST           = 4'h0;
  localparam logic [CNT_W-1:0] TARGET_RST         = 16'h0000;
  localparam logic [31:0]      CAPACITY_VAL       = 32'h0000_0004;
  localparam logic [31:0]      ORDER_OLDEST_FIRST = 32'h0000_0000;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              last;
  } ibtq_beat_s;

endpackage : ibtq_pkg

// >>> ibtq_transfer_queue.sv
// image block transfer queue: slot store, oldest-first sender and control registers
// Operation
// - only finished blocks enter the queue; the code queues a block at its first beat
// - start sending once one packet is buffered
// - consecutive blocks leave with no gap
// - unsent blocks wait in the queue
// - readable queue capacity value
// - readable present queue occupancy
// - oldest queued block always goes next
// - full queue overwrites oldest block not sending
// - each overwrite bumps the lost counter
// - after a block ends send the oldest
// - user method offers continuous or counted mode
// - continuous mode gated by go and halt
// - counted mode sends target blocks then stops
// - counted transfer begins only on go
// - acquisition state leaves queue untouched
// - closing channel empties queue and pending sends
// - halt lets the current block finish
// - block target used only in counted mode
module ibtq_transfer_queue (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          in_valid_i,
  input  wire ibtq_pkg::ibtq_beat_s          in_beat_i,
  output logic                               out_valid_o,
  output ibtq_pkg::ibtq_beat_s               out_beat_o,
  input  wire logic                          out_ready_i,
  input  wire logic [ibtq_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [31:0]                   reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [31:0]                   reg_rdata_o
);
  import ibtq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [WORD_W-1:0] mem_q [NSLOT*MAXW];
  logic [PTR_W-1:0]  len_q [NSLOT];
  logic [NSLOT-1:0]  done_q;
  logic [SLOT_W-1:0] ord_q [NSLOT];
  logic [SLOT_W-1:0] ord1  [NSLOT];
  logic [SLOT_W-1:0] ord_d [NSLOT];
  logic [OCC_W-1:0]  occ_q, occ_d;
  logic              tx_active_q;
  logic [PTR_W-1:0]  rd_ptr_q;
  logic              wr_active_q;
  logic [SLOT_W-1:0] wr_slot_q;
  logic [PTR_W-1:0]  wr_ptr_q;
  logic              skip_q;
  logic [31:0]       lost_q;
  logic [CNT_W-1:0]  sent_q;
  logic              run_q;
  logic [3:0]        ctrl_q;
  logic [CNT_W-1:0]  target_q;
  logic              out_valid_q;
  ibtq_beat_s        out_beat_q;
  logic [31:0]       rdata_q;
  logic [NSLOT-1:0]  busy;
  logic [SLOT_W-1:0] free_idx;
  logic [SLOT_W-1:0] new_slot;

  ////////////////////////////////////////////////////////////////////////////
  // control decode
  wire [1:0] method    = ctrl_q[CTRL_METHOD_LSB +: 2];
  wire       user_m    = (method == METHOD_USER);
  wire       multi_m   = user_m && (ctrl_q[CTRL_MODE_BIT] == MODE_MULTI);
  wire       chan_open = ctrl_q[CTRL_OPEN_BIT];
  wire       flush     = !chan_open;
  wire       cmd_wr    = reg_wr_i && (reg_addr_i == OFS_CMD);
  wire       go_cmd    = cmd_wr && reg_wdata_i[CMD_GO_BIT] && user_m;
  wire       halt_cmd  = cmd_wr && reg_wdata_i[CMD_HALT_BIT] && user_m;
  // a mode flip must not carry run over, or a counted transfer starts unasked
  wire       mode_chg  = reg_wr_i && (reg_addr_i == OFS_CTRL) &&
                         (reg_wdata_i[CTRL_MODE_BIT] != ctrl_q[CTRL_MODE_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // queue order bookkeeping
  wire              pop      = out_valid_q && out_ready_i && out_beat_q.last;
  wire [OCC_W-1:0]  occ1     = occ_q - OCC_W'(pop);
  wire [SLOT_W-1:0] head1    = pop ? ord_q[1] : ord_q[0];
  wire              tx_act1  = tx_active_q && !pop;
  wire              full1    = (occ1 == OCC_FULL);
  wire              head_rdy = (occ1 != '0) &&
                               ((len_q[head1] >= PKT_WORDS) || done_q[head1]);
  wire              multi_end = multi_m && pop && ((sent_q + 16'h0001) == target_q);
  // counted-mode end is taken in the same cycle so no extra block slips out
  wire              allow    = !user_m || (run_q && !multi_end);
  wire              tx_go    = !tx_act1 && head_rdy && allow && !flush;
  wire              eff_on   = tx_act1 || tx_go;
  wire              start_blk = in_valid_i && !wr_active_q && !skip_q && chan_open;
  wire              overflow = start_blk && full1;
  // the block on the wire is never the victim
  wire [SLOT_W-1:0] vpos     = eff_on ? SLOT_W'(1) : SLOT_W'(0);

  always_comb begin
    busy = '0;
    for (int i = 0; i < NSLOT; i++) begin
      ord1[i] = (pop && i < NSLOT - 1) ? ord_q[i + 1] : ord_q[i];
      if (OCC_W'(i) < occ1) begin
        busy[ord1[i]] = 1'b1;
      end
    end
  end

  ibtq_free_pick #(
    .N (NSLOT),
    .W (SLOT_W)
  ) u_pick (
    .busy_i (busy),
    .idx_o  (free_idx)
  );

  always_comb begin
    new_slot = free_idx;
    occ_d    = occ1;
    for (int i = 0; i < NSLOT; i++) begin
      ord_d[i] = ord1[i];
    end
    if (overflow) begin
      new_slot = ord1[vpos];
      for (int i = 0; i < NSLOT - 1; i++) begin
        if (SLOT_W'(i) >= vpos) begin
          ord_d[i] = ord1[i + 1];
        end
      end
      ord_d[NSLOT-1] = new_slot;
    end else if (start_blk) begin
      ord_d[occ1[SLOT_W-1:0]] = new_slot;
      occ_d = occ1 + OCC_W'(1);
    end
    if (flush) begin
      occ_d = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      occ_q <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        ord_q[i] <= '0;
      end
    end else begin
      occ_q <= occ_d;
      for (int i = 0; i < NSLOT; i++) begin
        ord_q[i] <= ord_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write side: filled whether or not streaming runs
  wire              wr_more = in_valid_i && wr_active_q;
  wire              wr_en   = start_blk || wr_more;
  wire [SLOT_W-1:0] wslot   = start_blk ? new_slot : wr_slot_q;
  wire [PTR_W-1:0]  wptr    = start_blk ? '0 : wr_ptr_q;
  // oversize blocks are cut at the slot size and the tail is skipped
  wire              wr_end  = in_beat_i.last || (wptr == LAST_PTR);

  always_ff @(posedge core_clk_i) begin
    if (wr_en) begin
      mem_q[{wslot, wptr[PTR_W-2:0]}] <= in_beat_i.data;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_active_q <= 1'b0;
      wr_slot_q   <= '0;
      wr_ptr_q    <= '0;
      skip_q      <= 1'b0;
      done_q      <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        len_q[i] <= '0;
      end
    end else if (flush) begin
      wr_active_q <= 1'b0;
      skip_q      <= (wr_active_q || skip_q) && !(in_valid_i && in_beat_i.last);
    end else begin
      if (wr_en) begin
        len_q[wslot]  <= wptr + PTR_W'(1);
        done_q[wslot] <= wr_end;
        wr_slot_q     <= wslot;
        wr_ptr_q      <= wptr + PTR_W'(1);
        wr_active_q   <= !wr_end;
        skip_q        <= wr_end && !in_beat_i.last;
      end else if (skip_q && in_valid_i && in_beat_i.last) begin
        skip_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // send side: head slot, cut-through once a packet is buffered
  wire [PTR_W-1:0]  eff_ptr  = tx_go ? '0 : rd_ptr_q;
  wire              can_load = eff_on && (!out_valid_q || out_ready_i) &&
                               (eff_ptr < len_q[head1]);
  wire              beat_last = done_q[head1] &&
                                ((eff_ptr + PTR_W'(1)) == len_q[head1]);
  wire [WORD_W-1:0] rd_word  = mem_q[{head1, eff_ptr[PTR_W-2:0]}];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_active_q <= 1'b0;
      rd_ptr_q    <= '0;
      out_valid_q <= 1'b0;
      out_beat_q  <= '0;
    end else if (flush) begin
      tx_active_q <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      tx_active_q <= eff_on;
      rd_ptr_q    <= can_load ? eff_ptr + PTR_W'(1) : eff_ptr;
      if (can_load) begin
        out_valid_q <= 1'b1;
        out_beat_q  <= '{data: rd_word, last: beat_last};
      end else if (out_ready_i) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // streaming permission and counters
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q  <= 1'b0;
      sent_q <= '0;
      lost_q <= '0;
    end else begin
      if (overflow) begin
        lost_q <= lost_q + 32'h0000_0001;
      end
      if (flush || !user_m || mode_chg) begin
        run_q <= 1'b0;
      end else if (go_cmd) begin
        // counted mode with a zero target never starts
        run_q  <= !multi_m || (target_q != '0);
        sent_q <= '0;
      end else if (halt_cmd || multi_end) begin
        run_q <= 1'b0;
      end else if (multi_m && pop && run_q) begin
        sent_q <= sent_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q   <= CTRL_RST;
      target_q <= TARGET_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFS_CTRL) begin
        ctrl_q <= reg_wdata_i[3:0];
      end
      if (reg_addr_i == OFS_TARGET) begin
        target_q <= reg_wdata_i[CNT_W-1:0];
      end
    end
  end

  wire [31:0] rd_sel =
    (reg_addr_i == OFS_CTRL)     ? {28'h0000000, ctrl_q} :
    (reg_addr_i == OFS_TARGET)   ? {16'h0000, target_q} :
    (reg_addr_i == OFS_CAPACITY) ? CAPACITY_VAL :
    (reg_addr_i == OFS_OCCUPY)   ? {29'h00000000, occ_q} :
    (reg_addr_i == OFS_LOST)     ? lost_q :
    (reg_addr_i == OFS_ORDER)    ? ORDER_OLDEST_FIRST :
    (reg_addr_i == OFS_STATUS)   ? {29'h00000000, run_q, tx_active_q, wr_active_q} :
                                   32'h0000_0000;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd_i ? rd_sel : 32'h0000_0000;
    end
  end

  assign out_valid_o = out_valid_q;
  assign out_beat_o  = out_beat_q;
  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_cut_through;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (tx_go) |=> (out_valid_q && tx_active_q);
  endproperty
  a_cut_through: assert property (p_cut_through) else $error("ready head not sent");

  property p_back_to_back;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (pop && head_rdy && allow && chan_open) |=> out_valid_q;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("gap between blocks");

  property p_capacity;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (reg_rd_i && reg_addr_i == OFS_CAPACITY) |=> (reg_rdata_o == 32'h0000_0004);
  endproperty
  a_capacity: assert property (p_capacity) else $error("capacity read wrong");

  property p_occ_grow;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (start_blk && !full1 && !pop && chan_open) |=> (occ_q == $past(occ_q) + 3'h1);
  endproperty
  a_occ_grow: assert property (p_occ_grow) else $error("occupancy not grown");

  property p_victim;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (overflow && eff_on) |-> (new_slot != head1);
  endproperty
  a_victim: assert property (p_victim) else $error("sending block overwritten");

  property p_lost;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (overflow) |=> (lost_q == $past(lost_q) + 32'h0000_0001) && (occ_q == OCC_FULL);
  endproperty
  a_lost: assert property (p_lost) else $error("lost count not bumped");

  property p_multi_stop;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (multi_end && chan_open && !go_cmd) |=> !run_q ##1 !tx_active_q;
  endproperty
  a_multi_stop: assert property (p_multi_stop) else $error("counted mode overran");

  property p_flush;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (!chan_open) |=> (occ_q == '0) && !out_valid_q && !tx_active_q && !run_q;
  endproperty
  a_flush: assert property (p_flush) else $error("closed channel not flushed");

  property p_halt_finish;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (halt_cmd && tx_active_q && !pop && chan_open) |=> tx_active_q;
  endproperty
  a_halt_finish: assert property (p_halt_finish) else $error("halt cut a block");

  property p_auto_ignore;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (cmd_wr && !user_m) |=> !run_q;
  endproperty
  a_auto_ignore: assert property (p_auto_ignore) else $error("command acted on");

endmodule : ibtq_transfer_queue

// >>> tb.sv
// self-checking bench for the image block transfer queue
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ibtq_pkg::*;

  logic              core_clk;
  logic              rst_b;
  logic              in_valid;
  ibtq_beat_s        in_beat;
  logic              out_valid;
  ibtq_beat_s        out_beat;
  logic              out_ready;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              hold;
  logic              slow;
  int                mismatches;
  int                total_checks;
  int unsigned       t_end;
  ibtq_beat_s        exp_q[$];

  ibtq_transfer_queue u_dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .in_valid_i(in_valid),
    .in_beat_i(in_beat), .out_valid_o(out_valid), .out_beat_o(out_beat),
    .out_ready_i(out_ready), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

  ibtq_link_sink u_sink (.core_clk_i(core_clk), .rst_b_i(rst_b), .valid_i(out_valid),
    .beat_i(out_beat), .hold_i(hold), .slow_i(slow), .ready_o(out_ready));

  ////////////////////////////////////////////////////////////////////////////////
  always #12.5 core_clk = ~core_clk;

  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    check({1'b0, reg_rdata}, {1'b0, e});
  endtask : rd

  // leaves in_valid high so blocks can follow back to back; idle() drops it
  task automatic send(input logic [7:0] id, input logic [7:0] n, input logic keep);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      in_valid     <= 1'b1;
      in_beat.data <= {8'h00, id, 8'h00, 8'(k)};
      in_beat.last <= (k == n - 1);
      if (keep) begin
        exp_q.push_back({8'h00, id, 8'h00, 8'(k), k == n - 1});
      end
    end
  endtask : send

  task automatic idle();
    @(posedge core_clk);
    in_valid <= 1'b0;
  endtask : idle

  task automatic drain();
    for (int i = 0; i < 400 && u_sink.got.size() < exp_q.size(); i++) begin
      @(posedge core_clk);
    end
    repeat (20) @(posedge core_clk);
    check(33'(u_sink.got.size()), 33'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < u_sink.got.size(); i++) begin
      check(u_sink.got[i], exp_q[i]);
    end
    u_sink.got.delete();
    u_sink.stamp.delete();
    exp_q.delete();
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    logic [ADDR_W-1:0] ra[9];
    logic [31:0]       re[9];
    ra = '{OFS_CAPACITY, OFS_ORDER, OFS_OCCUPY, OFS_LOST, OFS_CTRL, OFS_TARGET, OFS_CMD,
           OFS_STATUS, 8'h20};
    re = '{32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    core_clk = 1'b0;
    rst_b = 1'b0;
    in_valid = 1'b0;
    in_beat = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hold = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) rd(ra[i], re[i]);
    wr(OFS_CAPACITY, 32'h9);
    rd(OFS_CAPACITY, CAPACITY_VAL);
    // basic method, halt must be ignored, three blocks stream gap-free
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CMD, 32'h2);
    send(8'h01, 8'h08, 1'b1);
    t_end = u_sink.cyc;
    send(8'h02, 8'h08, 1'b1);
    send(8'h03, 8'h08, 1'b1);
    idle();
    repeat (40) @(posedge core_clk);
    check(33'(u_sink.stamp[0] < t_end), 33'h1);
    check(33'(u_sink.stamp[23] - u_sink.stamp[0]), 33'h17);
    drain();
    // auto method, stalled link: 14 overwrites 11, 15 overwrites 12
    wr(OFS_CTRL, 32'h9);
    hold <= 1'b1;
    for (int b = 8'h10; b < 8'h16; b++) send(8'(b), 8'h02, b == 8'h10 || b > 8'h12);
    idle();
    rd(OFS_OCCUPY, 32'h4);
    rd(OFS_LOST, 32'h2);
    rd(OFS_STATUS, 32'h2);
    hold <= 1'b0;
    drain();
    rd(OFS_OCCUPY, 32'h0);
    // closing the channel flushes a queued block
    hold <= 1'b1;
    send(8'h20, 8'h02, 1'b0);
    idle();
    wr(OFS_CTRL, 32'h0);
    rd(OFS_OCCUPY, 32'h0);
    check({32'h0, out_valid}, 33'h0);
    wr(OFS_CTRL, 32'hB);
    hold <= 1'b0;
    send(8'h21, 8'h05, 1'b1);
    idle();
    drain();
    // user continuous: nothing leaves before go, target is ignored
    wr(OFS_TARGET, 32'h1);
    wr(OFS_CTRL, 32'hA);
    send(8'h30, 8'h03, 1'b0);
    idle();
    drain();
    rd(OFS_OCCUPY, 32'h1);
    wr(OFS_CMD, 32'h1);
    send(8'h30, 8'h00, 1'b0);
    exp_q.push_back({8'h00, 8'h30, 8'h00, 8'h00, 1'b0});
    exp_q.push_back({8'h00, 8'h30, 8'h00, 8'h01, 1'b0});
    exp_q.push_back({8'h00, 8'h30, 8'h00, 8'h02, 1'b1});
    drain();
    hold <= 1'b1;
    send(8'h31, 8'h0C, 1'b1);
    send(8'h32, 8'h02, 1'b0);
    idle();
    wr(OFS_CMD, 32'h2);
    hold <= 1'b0;
    drain();
    rd(OFS_OCCUPY, 32'h1);
    wr(OFS_CMD, 32'h1);
    exp_q.push_back({8'h00, 8'h32, 8'h00, 8'h00, 1'b0});
    exp_q.push_back({8'h00, 8'h32, 8'h00, 8'h01, 1'b1});
    drain();
    // user counted: target programmed first, exactly two of three leave after go
    wr(OFS_TARGET, 32'h2);
    wr(OFS_CTRL, 32'hE);
    send(8'h40, 8'h03, 1'b1);
    send(8'h41, 8'h03, 1'b1);
    send(8'h42, 8'h03, 1'b0);
    idle();
    check(33'(u_sink.got.size()), 33'h0);
    slow <= 1'b1;
    wr(OFS_CMD, 32'h1);
    drain();
    rd(OFS_OCCUPY, 32'h1);
    rd(OFS_STATUS, 32'h0);
    end_sim();
  end
endmodule : tb
